// ===== hdl/isled_top.sv
// ignition switch decoding and front-panel led drive
// assumes switch pins are asynchronous; controller inputs share clk_in
//
// What this block does
// R1: with front panel disabled, ignore switch and drive leds off.
// R2: stop position forces lockout and stop alarm; run alone does nothing.
// R3: ignite under 1s ignored; 1s to 10s starts up only from ready.
// R4: ignite held over 10s forces lockout and raises switch-stuck alarm.
// R5: in lockout, run then stop then run acknowledges, returning to ready.
// R6: status solid red when stopped in ready.
// R7: status slow red flash when stopped with an alarm.
// R8: status fast red flash when stopped in lockout.
// R9: status solid amber when running with warnings and no waits.
// R10: status slow amber flash when running with waits and warnings.
// R11: status solid green when running with no waits or warnings.
// R12: status slow green flash when running with waits and no warnings.
// R13: main led follows the safety shutoff valve outputs.
// R14: pilot led follows the pilot valve output.
// R15: igniting led lit while any ignition coil is energized.
// R16: fixed slow and fast flash periods, fast at least twice slow.
// R17: hold timer runs while in ignite; decision on release or at 10s.
module isled_top #(
   parameter logic [31:0] IGN_MIN = isled_pkg::IGN_MIN_CYC,
   parameter logic [31:0] IGN_MAX = isled_pkg::IGN_MAX_CYC,
   parameter logic [31:0] SLOW_HALF = isled_pkg::SLOW_HALF_CYC,
   parameter logic [31:0] FAST_HALF = isled_pkg::FAST_HALF_CYC
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic front_panel_enable_in,
   input wire logic sw_stop_in,
   input wire logic sw_ignite_in,
   input wire isled_pkg::isled_ctrl_s ctrl_in,
   input wire logic safety_shutoff_valves_in,
   input wire logic pilot_valve_in,
   input wire logic [isled_pkg::COIL_NUM-1:0] coil_on_in,
   output isled_pkg::isled_req_s req_out,
   output isled_pkg::isled_leds_s leds_out
);
   logic stop_s1_r, stop_s2_r, ign_s1_r, ign_s2_r;
   isled_pkg::isled_pos_e pos_r, pos_nxt;
   logic [31:0] ign_cnt_r, ign_cnt_nxt;
   logic armed_r, armed_nxt, seen_stop_r, seen_stop_nxt;
   isled_pkg::isled_req_s req_r, req_nxt;
   logic [31:0] slow_cnt_r, slow_cnt_nxt, fast_cnt_r, fast_cnt_nxt;
   logic slow_ph_r, slow_ph_nxt, fast_ph_r, fast_ph_nxt;
   isled_pkg::isled_leds_s leds_r, leds_nxt;
   logic en, release_ev, held_ok;

   // two-stage synchronisers for the switch pins
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         stop_s1_r <= 1'h0;
         stop_s2_r <= 1'h0;
         ign_s1_r <= 1'h0;
         ign_s2_r <= 1'h0;
      end else begin
         stop_s1_r <= sw_stop_in;
         stop_s2_r <= stop_s1_r;
         ign_s1_r <= sw_ignite_in;
         ign_s2_r <= ign_s1_r;
      end
   end

   assign en = front_panel_enable_in;
   assign release_ev = (pos_r == isled_pkg::POS_IGNITE) && (pos_nxt != isled_pkg::POS_IGNITE);
   assign held_ok = (ign_cnt_r >= IGN_MIN) && (ign_cnt_r < IGN_MAX);

   // switch decoding, hold timer and lockout acknowledge
   always_comb begin
      // stop wins if both contacts read closed, the safe reading
      if (stop_s2_r) begin
         pos_nxt = isled_pkg::POS_STOP;
      end else if (ign_s2_r) begin
         pos_nxt = isled_pkg::POS_IGNITE;
      end else begin
         pos_nxt = isled_pkg::POS_RUN;
      end
      ign_cnt_nxt = 32'h0;
      armed_nxt = armed_r;
      seen_stop_nxt = seen_stop_r;
      req_nxt = '0;
      case (pos_r)
         isled_pkg::POS_IGNITE: begin
            // R17 hold timer runs
            if (ign_cnt_r != IGN_MAX) begin
               ign_cnt_nxt = ign_cnt_r + 32'h1;
            end else begin
               ign_cnt_nxt = ign_cnt_r;
            end
         end
         isled_pkg::POS_RUN, isled_pkg::POS_STOP: ign_cnt_nxt = 32'h0;
         default: ign_cnt_nxt = 32'h0;
      endcase
      // R2 stop forces lockout
      if (pos_r != isled_pkg::POS_STOP && pos_nxt == isled_pkg::POS_STOP) begin
         req_nxt.lockout = 1'h1;
         req_nxt.stop_alarm = 1'h1;
      end
      // R4 stuck switch fires once
      if (pos_r == isled_pkg::POS_IGNITE && pos_nxt == isled_pkg::POS_IGNITE
          && ign_cnt_r == IGN_MAX - 32'h1) begin
         req_nxt.lockout = 1'h1;
         req_nxt.stuck_alarm = 1'h1;
      end
      // R3 startup on release
      if (release_ev && held_ok && ctrl_in.ready && !ctrl_in.lockout) begin
         req_nxt.startup = 1'h1;
      end
      // R5 run, stop, run sequence in lockout
      if (!ctrl_in.lockout) begin
         armed_nxt = 1'h0;
         seen_stop_nxt = 1'h0;
      end else if (pos_r == isled_pkg::POS_RUN && !seen_stop_r) begin
         armed_nxt = 1'h1;
      end else if (pos_r == isled_pkg::POS_STOP && armed_r) begin
         seen_stop_nxt = 1'h1;
      end
      if (ctrl_in.lockout && seen_stop_r && pos_r == isled_pkg::POS_STOP
          && pos_nxt == isled_pkg::POS_RUN) begin
         req_nxt.ack = 1'h1;
         armed_nxt = 1'h0;
         seen_stop_nxt = 1'h0;
      end
      // R1 switch ignored when disabled
      if (!en) begin
         req_nxt = '0;
         ign_cnt_nxt = 32'h0;
         armed_nxt = 1'h0;
         seen_stop_nxt = 1'h0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         pos_r <= isled_pkg::POS_RUN;
         ign_cnt_r <= 32'h0;
         armed_r <= 1'h0;
         seen_stop_r <= 1'h0;
         req_r <= '0;
      end else begin
         pos_r <= pos_nxt;
         ign_cnt_r <= ign_cnt_nxt;
         armed_r <= armed_nxt;
         seen_stop_r <= seen_stop_nxt;
         req_r <= req_nxt;
      end
   end

   // flash dividers and led drive
   always_comb begin
      // R16 free-running flash phases
      slow_cnt_nxt = slow_cnt_r + 32'h1;
      slow_ph_nxt = slow_ph_r;
      if (slow_cnt_r == SLOW_HALF - 32'h1) begin
         slow_cnt_nxt = 32'h0;
         slow_ph_nxt = !slow_ph_r;
      end
      fast_cnt_nxt = fast_cnt_r + 32'h1;
      fast_ph_nxt = fast_ph_r;
      if (fast_cnt_r == FAST_HALF - 32'h1) begin
         fast_cnt_nxt = 32'h0;
         fast_ph_nxt = !fast_ph_r;
      end
      leds_nxt = '0;
      if (!ctrl_in.running) begin
         // R8 lockout flashes fast, highest stopped priority
         if (ctrl_in.lockout) begin
            leds_nxt.red = fast_ph_r;
         // R7 alarm flashes slow
         end else if (ctrl_in.alarm) begin
            leds_nxt.red = slow_ph_r;
         // R6 ready shows solid
         end else if (ctrl_in.ready) begin
            leds_nxt.red = 1'h1;
         end
      end else if (ctrl_in.warning) begin
         // R9 R10 amber on warnings
         leds_nxt.amber = ctrl_in.waiting ? slow_ph_r : 1'h1;
      end else begin
         // R11 R12 green otherwise
         leds_nxt.green = ctrl_in.waiting ? slow_ph_r : 1'h1;
      end
      // R13 main valve indicator
      leds_nxt.main = safety_shutoff_valves_in;
      // R14 pilot valve indicator
      leds_nxt.pilot = pilot_valve_in;
      // R15 any coil lights it
      leds_nxt.igniting = |coil_on_in;
      // R1 board unused when disabled
      if (!en) begin
         leds_nxt = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         slow_cnt_r <= 32'h0;
         fast_cnt_r <= 32'h0;
         slow_ph_r <= 1'h0;
         fast_ph_r <= 1'h0;
         leds_r <= '0;
      end else begin
         slow_cnt_r <= slow_cnt_nxt;
         fast_cnt_r <= fast_cnt_nxt;
         slow_ph_r <= slow_ph_nxt;
         fast_ph_r <= fast_ph_nxt;
         leds_r <= leds_nxt;
      end
   end

   assign req_out = req_r;
   assign leds_out = leds_r;

   // checks on the outputs against their causes
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   disabled_quiet_a: assert property (!en |=> req_r == '0 && leds_r == '0) // R1
      else $error("outputs active while front panel disabled");
   stop_lock_a: assert property (en && pos_r != isled_pkg::POS_STOP // R2
         && pos_nxt == isled_pkg::POS_STOP |=> req_r.lockout && req_r.stop_alarm)
      else $error("stop did not force lockout");
   run_quiet_a: assert property (en && pos_r == isled_pkg::POS_RUN // R2
         && pos_nxt == isled_pkg::POS_RUN |=> !req_r.lockout && !req_r.startup)
      else $error("run position caused an action");
   short_press_a: assert property (release_ev && ign_cnt_r < IGN_MIN |=> !req_r.startup) // R3
      else $error("short ignite press started up");
   start_ready_a: assert property (en && release_ev && held_ok && ctrl_in.ready // R3
         && !ctrl_in.lockout |=> req_r.startup)
      else $error("valid ignite press did not start up");
   stuck_a: assert property (en && pos_r == isled_pkg::POS_IGNITE // R4
         && pos_nxt == isled_pkg::POS_IGNITE && ign_cnt_r == IGN_MAX - 32'h1
         |=> req_r.stuck_alarm && req_r.lockout)
      else $error("stuck switch not reported");
   ack_seq_a: assert property (req_r.ack |-> $past(seen_stop_r) && $past(ctrl_in.lockout)) // R5
      else $error("acknowledge without run-stop-run");
   red_fast_a: assert property (en && !ctrl_in.running && ctrl_in.lockout // R8
         |=> leds_r.red == $past(fast_ph_r) && !leds_r.green)
      else $error("lockout red flash wrong");
   red_solid_a: assert property (en && !ctrl_in.running && !ctrl_in.lockout // R6
         && !ctrl_in.alarm && ctrl_in.ready |=> leds_r.red && !leds_r.amber)
      else $error("ready red not solid");
   green_solid_a: assert property (en && ctrl_in.running && !ctrl_in.warning // R11
         && !ctrl_in.waiting |=> leds_r.green && !leds_r.red && !leds_r.amber)
      else $error("running green not solid");
   blue_follow_a: assert property (en |=> leds_r.main == $past(safety_shutoff_valves_in) // R13
         && leds_r.pilot == $past(pilot_valve_in) && leds_r.igniting == |$past(coil_on_in))
      else $error("blue leds do not follow outputs");
   fast_rate_a: assert property ($changed(fast_ph_r) |-> $past(fast_cnt_r) == FAST_HALF - 32'h1) // R16
      else $error("fast flash period wrong");
   timer_clear_a: assert property (pos_r != isled_pkg::POS_IGNITE |=> ign_cnt_r == 32'h0) // R17
      else $error("hold timer not cleared");

   startup_c: cover property (req_r.startup);
   stuck_c: cover property (req_r.stuck_alarm);
   ack_c: cover property (req_r.ack);
endmodule // isled_top

// ===== hdl/isled_pkg.sv
// package for the ignition switch and front-panel led block
// assumes a 200 MHz controller clock; all timings below derive from it
package isled_pkg;
   // clock rate and printed times, in their own units
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned IGN_MIN_MS = 1000;
   localparam int unsigned IGN_MAX_MS = 10000;
   // flash half-periods, fast is four times the slow rate
   localparam int unsigned SLOW_HALF_MS = 500;
   localparam int unsigned FAST_HALF_MS = 125;
   // cycle counts derived from the times (all divide exactly)
   localparam logic [31:0] IGN_MIN_CYC = 32'(CYC_PER_MS * IGN_MIN_MS);
   localparam logic [31:0] IGN_MAX_CYC = 32'(CYC_PER_MS * IGN_MAX_MS);
   localparam logic [31:0] SLOW_HALF_CYC = 32'(CYC_PER_MS * SLOW_HALF_MS);
   localparam logic [31:0] FAST_HALF_CYC = 32'(CYC_PER_MS * FAST_HALF_MS);
   // number of ignition coil outputs watched
   localparam int COIL_NUM = 2;

   // synchronised switch position, not debounced
   typedef enum logic [1:0] {POS_RUN, POS_STOP, POS_IGNITE} isled_pos_e;

   // controller state seen by this block
   typedef struct packed {
      logic ready;
      logic lockout;
      logic running;
      logic alarm;
      logic warning;
      logic waiting;
   } isled_ctrl_s;

   // one-cycle requests towards the controller state machine
   typedef struct packed {
      logic startup;
      logic lockout;
      logic stop_alarm;
      logic stuck_alarm;
      logic ack;
   } isled_req_s;

   // led board drive, high means lit
   typedef struct packed {
      logic red;
      logic amber;
      logic green;
      logic main;
      logic pilot;
      logic igniting;
   } isled_leds_s;
endpackage

// ===== verification/isled_operator.sv
// operator ignition switch model: drives the stop and ignite contacts
// assumes the bench clock; contacts change only just after a rising edge
module isled_operator (
   input wire logic clk_in,
   output logic sw_stop_out,
   output logic sw_ignite_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // switch rests in run, both contacts open
   initial begin
      sw_stop_out = 1'b0;
      sw_ignite_out = 1'b0;
   end

   // ignite held n cycles, then back to run
   task automatic hold_ignite(input int n);
      @(posedge clk_in) sw_ignite_out <= 1'b1;
      repeat (n) @(posedge clk_in);
      sw_ignite_out <= 1'b0;
   endtask

   // run to stop to run, stop held n cycles
   task automatic hold_stop(input int n);
      @(posedge clk_in) sw_stop_out <= 1'b1;
      repeat (n) @(posedge clk_in);
      sw_stop_out <= 1'b0;
   endtask
endmodule // isled_operator

// ===== verification/tb_ignition_switch_and_status_leds.sv
// self-checking bench for the switch decoder and led drive
// assumes short hold and flash counts so the run stays brief
module tb_ignition_switch_and_status_leds;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P_MIN = 10;
   localparam int P_MAX = 50;
   logic clk_in = 1'b0, rstn_in = 1'b0, fp_en = 1'b0, safety_shutoff_valves = 1'b0, pilot = 1'b0;
   logic sw_stop, sw_ignite;
   logic [isled_pkg::COIL_NUM-1:0] coil = '0;
   isled_pkg::isled_ctrl_s ctrl = '0;
   isled_pkg::isled_req_s req;
   isled_pkg::isled_leds_s leds;
   int cnt[5];
   int err_total = 0, checks = 0, cycles = 0;

   isled_top #(.IGN_MIN(32'h0000000a), .IGN_MAX(32'h00000032), .SLOW_HALF(32'h00000008),
      .FAST_HALF(32'h00000002)) dut (.clk_in(clk_in), .rstn_in(rstn_in),
      .front_panel_enable_in(fp_en), .sw_stop_in(sw_stop), .sw_ignite_in(sw_ignite),
      .ctrl_in(ctrl), .safety_shutoff_valves_in(safety_shutoff_valves), .pilot_valve_in(pilot),
      .coil_on_in(coil), .req_out(req), .leds_out(leds));
   isled_operator op (.clk_in(clk_in), .sw_stop_out(sw_stop), .sw_ignite_out(sw_ignite));

   always #2.5 clk_in = ~clk_in;

   // count request pulses; the cycle ceiling cuts a hang short
   always @(posedge clk_in) begin
      for (int i = 0; i < 5; i++) cnt[i] += (req[i] === 1'b1);
      cycles++;
      if (cycles == 12000) begin
         err_total++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk_req(input string what, input logic [4:0] exp);
      logic [4:0] got;
      for (int i = 0; i < 5; i++) got[i] = cnt[i] == 0 ? 1'b0 : cnt[i] == 1 ? 1'b1 : 1'bx;
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk_led(input string what, input logic [5:0] exp, input logic [5:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // model of requests: one pulse per kind, in bit order of the request struct
   // a press is timed from the cycle after it is first seen, so n pin cycles give n - 1 counts
   function automatic logic [4:0] want_req(input bit en, stp, input int n,
      input isled_pkg::isled_ctrl_s c);
      if (!en) return 5'h00;
      if (stp) return c.lockout ? 5'h0d : 5'h0c;
      if (n > P_MAX) return 5'h0a;
      if (n > P_MIN && c.ready && !c.lockout) return 5'h10;
      return 5'h00;
   endfunction

   // model of the status led: lit colour and flash class (0 solid, 1 slow, 2 fast)
   function automatic logic [4:0] want_status(input isled_pkg::isled_ctrl_s c);
      if (!c.running) begin
         if (c.lockout) return 5'h12;
         if (c.alarm) return 5'h11;
         if (c.ready) return 5'h10;
         return 5'h00;
      end
      if (c.warning) return {3'h2, 1'b0, c.waiting};
      return {3'h1, 1'b0, c.waiting};
   endfunction

   task automatic req_case(input string name, input bit en, stp, input int n,
      input isled_pkg::isled_ctrl_s c);
      fp_en <= en;
      ctrl <= c;
      repeat (8) @(posedge clk_in);
      #1 cnt = '{default: 0};
      if (stp) op.hold_stop(n);
      else op.hold_ignite(n);
      repeat (12) @(posedge clk_in);
      chk_req(name, want_req(en, stp, n, c));
      $display("test %s done", name);
   endtask

   // watch 48 cycles; a slow flash toggles about 6 times, a fast one about 24
   task automatic status_case(input isled_pkg::isled_ctrl_s c);
      logic [2:0] lit, prev;
      logic [1:0] cls;
      int t;
      // inputs change only on a rising edge
      @(posedge clk_in);
      ctrl <= c;
      repeat (3) @(posedge clk_in);
      #1 lit = leds[5:3];
      prev = lit;
      t = 0;
      repeat (48) begin
         @(posedge clk_in);
         #1 lit |= leds[5:3];
         if (leds[5:3] !== prev) t++;
         prev = leds[5:3];
      end
      cls = t == 0 ? 2'h0 : (t >= 5 && t <= 7) ? 2'h1 : (t >= 23 && t <= 25) ? 2'h2 : 2'h3;
      chk_led("status", {1'b0, want_status(c)}, {1'b0, lit, cls});
   endtask

   initial begin
      void'($urandom(29));
      repeat (6) @(posedge clk_in);
      rstn_in <= 1'b1;
      req_case("short", 1'b1, 1'b0, 4, 6'h20);
      req_case("start", 1'b1, 1'b0, 12 + $urandom % 30, 6'h20);
      req_case("min_short", 1'b1, 1'b0, P_MIN, 6'h20);
      req_case("min_ok", 1'b1, 1'b0, P_MIN + 1, 6'h20);
      req_case("max_ok", 1'b1, 1'b0, P_MAX, 6'h20);
      req_case("max_stuck", 1'b1, 1'b0, P_MAX + 1, 6'h20);
      req_case("busy", 1'b1, 1'b0, 25, 6'h08);
      req_case("locked", 1'b1, 1'b0, 25, 6'h30);
      req_case("stuck", 1'b1, 1'b0, 70, 6'h20);
      req_case("stop", 1'b1, 1'b1, 5, 6'h20);
      req_case("ack", 1'b1, 1'b1, 5, 6'h10);
      req_case("off_ign", 1'b0, 1'b0, 25, 6'h20);
      req_case("off_stop", 1'b0, 1'b1, 5, 6'h20);
      fp_en <= 1'b1;
      for (int i = 0; i < 64; i++) status_case(6'(i));
      $display("test status done");
      // random valve and coil levels, including the disabled setting
      for (int i = 0; i < 40; i++) begin
         @(posedge clk_in);
         fp_en <= (i < 30);
         // stopped with nothing set keeps the status led dark
         ctrl <= '0;
         {safety_shutoff_valves, pilot, coil} <= 4'($urandom);
         repeat (2) @(posedge clk_in);
         #1 chk_led("blue", fp_en ? {3'h0, safety_shutoff_valves, pilot, |coil} : 6'h00, leds);
      end
      $display("test blue done");
      print_verdict();
   end
endmodule // tb_ignition_switch_and_status_leds
